// >>> dv/cdh_host_model.sv
// Microprocessor model driving the parallel host port
`timescale 1ns/10ps
module cdh_host_model (
    input wire logic ref_clk,
    output logic register_select,
    output logic direction_select,
    output logic strobe,
    output logic [3:0] low_nibble_lines_in,
    output logic [3:0] high_nibble_lines_in,
    input wire logic [3:0] low_nibble_lines_out,
    input wire logic [3:0] high_nibble_lines_out,
    input wire logic low_nibble_lines_oe_n,
    input wire logic high_nibble_lines_oe_n
);
    logic [3:0] drv_hi = 4'h0;
    logic [3:0] drv_lo = 4'h0;
    // Wire level: device wins while its enable is low
    assign high_nibble_lines_in = high_nibble_lines_oe_n ? drv_hi :
        high_nibble_lines_out;
    assign low_nibble_lines_in = low_nibble_lines_oe_n ? drv_lo :
        low_nibble_lines_out;
    initial begin
        register_select = 1'b0;
        direction_select = 1'b0;
        strobe = 1'b0;
    end
    // ==========================================
    // One strobed access
    task automatic pulse(input logic rs, input logic rd, input logic [3:0] hi,
        input logic [3:0] lo, output logic [3:0] q_hi, output logic [3:0] q_lo);
        @(posedge ref_clk);
        register_select <= rs;
        direction_select <= rd;
        drv_hi <= rd ? ~drv_hi : hi;
        drv_lo <= rd ? ~drv_lo : lo;
        @(posedge ref_clk);
        strobe <= 1'b1;
        repeat (3) @(posedge ref_clk);
        q_hi = high_nibble_lines_in;
        q_lo = low_nibble_lines_in;
        strobe <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    // ==========================================
    // One byte, split in four-bit mode
    task automatic xfer(input logic rs, input logic rd, input logic [7:0] wd,
        input logic nib4, output logic [7:0] q);
        logic [3:0] a;
        logic [3:0] b;
        logic [3:0] c;
        if (nib4) begin
            pulse(rs, rd, wd[7:4], 4'hF, a, b);
            pulse(rs, rd, wd[3:0], 4'hF, c, b);
            q = {a, c};
        end else begin
            pulse(rs, rd, wd[7:4], wd[3:0], a, b);
            q = {a, b};
        end
    endtask
endmodule

// >>> dv/cdh_host_port_bench.sv
// Self-checking bench for the character display host port
`timescale 1ns/10ps
module cdh_host_port_bench import cdh_pkg::*;;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic register_select, direction_select, strobe, nib4;
    logic [3:0] low_nibble_lines_in, high_nibble_lines_in;
    logic [3:0] low_nibble_lines_out, high_nibble_lines_out;
    logic low_nibble_lines_oe_n, high_nibble_lines_oe_n;
    logic host_ready, busy_indication, bus_8bit, two_line, tall_font;
    logic [6:0] address_pointer, window_line1, window_line2;
    logic [6:0] expansion_line1, expansion_line2;
    logic [4:0] duty;
    logic [15:0] common_active;
    logic [7:0] q;
    int err_count;
    int checks_done;

    always #5 ref_clk = ~ref_clk;

    cdh_host_port #(.EXEC_CYC(20)) dut_u (.ref_clk, .srst, .register_select,
        .direction_select, .strobe, .low_nibble_lines_in, .high_nibble_lines_in,
        .low_nibble_lines_out, .high_nibble_lines_out, .low_nibble_lines_oe_n,
        .high_nibble_lines_oe_n, .host_ready, .busy_indication,
        .address_pointer, .bus_8bit, .two_line, .tall_font, .duty,
        .common_active, .window_line1, .window_line2, .expansion_line1,
        .expansion_line2);
    cdh_host_model host_u (.ref_clk, .register_select, .direction_select,
        .strobe, .low_nibble_lines_in, .high_nibble_lines_in,
        .low_nibble_lines_out, .high_nibble_lines_out,
        .low_nibble_lines_oe_n, .high_nibble_lines_oe_n);

    // ==========================================
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("mismatches %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (4) @(posedge ref_clk);
        while (busy_indication !== 1'b0 && n < 1000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 1000) begin
            err_count++;
            results();
        end
    endtask
    task automatic op(input logic rs, input logic rd, input logic [7:0] d);
        host_u.xfer(rs, rd, d, nib4, q);
        if (!rd || rs) begin
            wait_idle();
        end
    endtask
    task automatic do_reset();
        srst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        nib4 = 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        err_count = 0;
        checks_done = 0;
        do_reset();
        check(common_active, 16'h00FF);
        op(1'b0, 1'b1, 8'h00);
        check(q, 8'h00);
        host_u.xfer(1'b0, 1'b0, 8'h90, nib4, q);
        op(1'b0, 1'b1, 8'h00);
        check(q[7], 1'b1);
        wait_idle();
        op(1'b0, 1'b1, 8'h00);
        check(q, 8'h10);
        op(1'b1, 1'b0, 8'h5A);
        op(1'b1, 1'b0, 8'hA5);
        op(1'b0, 1'b1, 8'h00);
        check(q, 8'h12);
        op(1'b0, 1'b0, 8'h90);
        op(1'b1, 1'b1, 8'h00);
        check(q, 8'h5A);
        op(1'b1, 1'b1, 8'h00);
        check(q, 8'hA5);
        op(1'b0, 1'b0, 8'h45);
        op(1'b1, 1'b0, 8'h1F);
        op(1'b0, 1'b0, 8'h45);
        op(1'b1, 1'b1, 8'h00);
        check(q, 8'h1F);
        op(1'b0, 1'b0, 8'h04);
        op(1'b0, 1'b0, 8'hCF);
        op(1'b1, 1'b0, 8'h77);
        check(address_pointer, 7'h4E);
        op(1'b0, 1'b0, 8'h28);
        nib4 = 1'b1;
        check(duty, CDH_DUTY_16);
        check(common_active, 16'hFFFF);
        op(1'b0, 1'b0, 8'h06);
        op(1'b0, 1'b0, 8'hE6);
        op(1'b1, 1'b0, 8'h3C);
        op(1'b0, 1'b0, 8'hE6);
        op(1'b1, 1'b1, 8'h00);
        check(q, 8'h3C);
        op(1'b0, 1'b1, 8'h00);
        check(q, 8'h67);
        op(1'b0, 1'b0, 8'h1C);
        check(window_line1, 7'h27);
        check(window_line2, 7'h67);
        check(expansion_line2, 7'h47);
        op(1'b0, 1'b0, 8'h18);
        op(1'b0, 1'b0, 8'h18);
        check(window_line2, 7'h41);
        op(1'b0, 1'b0, 8'h24);
        check(common_active, 16'h07FF);
        do_reset();
        op(1'b0, 1'b0, 8'h1C);
        check(window_line1, 7'h4F);
        check(expansion_line1, 7'h07);
        op(1'b0, 1'b0, 8'h14);
        check(address_pointer, 7'h01);
        op(1'b0, 1'b0, 8'h02);
        check(window_line1, 7'h00);
        for (int i = 0; i < 40 && host_ready !== 1'b0; i++) begin
            host_u.xfer(1'b0, 1'b0, 8'h06, nib4, q);
        end
        check(host_ready, 1'b0);
        wait_idle();
        check(host_ready, 1'b1);
        results();
    end
endmodule

// >>> dv/cdh_host_port_properties.sv
// Concurrent checks on the host port pins
`timescale 1ns/10ps
module cdh_props
    import cdh_pkg::*;
#(
    parameter int EXEC_CYC = CDH_EXEC_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic register_select,
    input wire logic direction_select,
    input wire logic strobe,
    input wire logic [3:0] low_nibble_lines_out,
    input wire logic [3:0] high_nibble_lines_out,
    input wire logic low_nibble_lines_oe_n,
    input wire logic high_nibble_lines_oe_n,
    input wire logic host_ready,
    input wire logic busy_indication,
    input wire logic [6:0] address_pointer,
    input wire logic bus_8bit,
    input wire logic two_line,
    input wire logic tall_font,
    input wire logic [4:0] duty,
    input wire logic [15:0] common_active,
    input wire logic [6:0] window_line1,
    input wire logic [6:0] expansion_line1
);
    localparam int BUSY_MAX = (EXEC_CYC + 4) * (2 * CDH_FIFO_DEPTH + 4);
    int busy_run;
    logic [6:0] ptr_fall;
    logic [7:0] stat_cap;
    // ==========================================
    // Helper logic
    always_ff @(posedge ref_clk) begin
        busy_run <= (srst || !busy_indication) ? 0 : busy_run + 1;
    end
    always_ff @(posedge ref_clk) begin
        if ($fell(strobe)) begin
            ptr_fall <= address_pointer;
        end
        if ($rose(strobe)) begin
            stat_cap <= {busy_indication, address_pointer};
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // ==========================================
    // Assertions
    a_busy_on_cmd: assert property (
        $fell(strobe) && !register_select && !direction_select && bus_8bit
        && host_ready |-> ##[1:3] busy_indication)
        else $error("busy did not follow a command write");
    a_busy_bounded: assert property (
        busy_run < BUSY_MAX) else $error("busy never cleared");
    a_full_busy: assert property (
        !host_ready |-> busy_indication) else $error("full but not busy");
    a_low_idle: assert property (
        !bus_8bit |-> low_nibble_lines_oe_n)
        else $error("low lines driven in four-bit mode");
    a_drive_read: assert property (
        (strobe && direction_select) [*3] |-> !high_nibble_lines_oe_n)
        else $error("read data not driven");
    a_status_word: assert property (
        $rose(strobe) && !register_select && direction_select && bus_8bit
        |=> ##[0:1] {high_nibble_lines_out, low_nibble_lines_out} == stat_cap)
        else $error("status word differs from busy and pointer");
    a_duty_commons: assert property (
        $stable(two_line) && $stable(tall_font) |-> duty == (two_line ?
        CDH_DUTY_16 : tall_font ? CDH_DUTY_11 : CDH_DUTY_8) &&
        common_active == (16'hFFFF >> (5'h10 - duty)))
        else $error("duty or commons do not match the mode");
    a_ptr_step: assert property (
        $fell(strobe) && register_select && direction_select && bus_8bit
        |=> ##[0:2] (address_pointer == ptr_fall + 7'h01 ||
        address_pointer == ptr_fall - 7'h01))
        else $error("pointer did not step after a data read");
    a_exp_gap: assert property (
        $stable(window_line1) && $stable(two_line) |-> expansion_line1 ==
        (two_line ? (window_line1 > 7'h1F ? window_line1 - 7'h20 :
        window_line1 + 7'h08) : (window_line1 > 7'h47 ?
        window_line1 - 7'h48 : window_line1 + 7'h08)))
        else $error("expansion address not eight past window");
endmodule

bind cdh_host_port cdh_props #(.EXEC_CYC(EXEC_CYC)) props_u (
    .ref_clk, .srst, .register_select, .direction_select, .strobe,
    .low_nibble_lines_out, .high_nibble_lines_out, .low_nibble_lines_oe_n,
    .high_nibble_lines_oe_n, .host_ready, .busy_indication,
    .address_pointer, .bus_8bit, .two_line, .tall_font, .duty,
    .common_active, .window_line1, .expansion_line1
);

// >>> rtl/cdh_fifo.sv
// Parameterised valid/ready FIFO for host write accesses
`timescale 1ns/10ps
module cdh_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// >>> rtl/cdh_host_port.sv
// Host parallel port, address pointer and display mapping
`timescale 1ns/10ps
module cdh_host_port
    import cdh_pkg::*;
#(
    parameter int EXEC_CYC = CDH_EXEC_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic register_select,
    input wire logic direction_select,
    input wire logic strobe,
    input wire logic [3:0] low_nibble_lines_in,
    input wire logic [3:0] high_nibble_lines_in,
    output logic [3:0] low_nibble_lines_out,
    output logic [3:0] high_nibble_lines_out,
    output logic low_nibble_lines_oe_n,
    output logic high_nibble_lines_oe_n,
    output logic host_ready,
    output logic busy_indication,
    output logic [6:0] address_pointer,
    output logic bus_8bit,
    output logic two_line,
    output logic tall_font,
    output logic [4:0] duty,
    output logic [15:0] common_active,
    output logic [6:0] window_line1,
    output logic [6:0] window_line2,
    output logic [6:0] expansion_line1,
    output logic [6:0] expansion_line2
);
    // ==================================================================
    // Storage and state
    logic [7:0] char_ram_r [CDH_DD_DEPTH];
    logic [7:0] glyph_ram_r [CDH_CG_DEPTH];
    logic [7:0] xfer_r;
    logic [6:0] ptr_r;
    logic cg_sel_r;
    logic inc_r;
    logic bus8_r;
    logic lines2_r;
    logic font10_r;
    logic [6:0] shift_r;
    cdh_state_e state_r;
    logic [7:0] cnt_r;
    logic strobe_d_r;
    logic nib_hi_r;
    logic [3:0] nib_hold_r;
    logic rd_hi_r;
    logic [7:0] rd_byte;
    logic fall;
    logic rise;
    logic byte_done;
    logic [7:0] wr_byte;
    logic fifo_ready;
    logic q_valid;
    logic q_pop;
    cdh_acc_s q_acc;
    cdh_acc_s in_acc;
    logic [6:0] step_ptr;
    logic [6:0] sh_nxt;
    logic [6:0] dd_idx;
    logic dd_ok;

    // ==================================================================
    // Strobe edge and nibble pairing
    assign fall = strobe_d_r & ~strobe;
    assign rise = ~strobe_d_r & strobe;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            strobe_d_r <= 1'b0;
        end else begin
            strobe_d_r <= strobe;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            nib_hi_r <= 1'b1;
            nib_hold_r <= 4'h0;
        end else if (fall && !bus8_r) begin
            nib_hi_r <= ~nib_hi_r;                             // [RULE22]
            if (nib_hi_r) begin
                nib_hold_r <= high_nibble_lines_in;            // [RULE14]
            end
        end
    end

    // Write byte is whole on a fall in 8-bit mode or second nibble
    assign byte_done = fall & ~direction_select              // [RULE2]
                     & (bus8_r | ~nib_hi_r);
    assign wr_byte = bus8_r ? {high_nibble_lines_in, low_nibble_lines_in}
                            : {nib_hold_r, high_nibble_lines_in};  // [RULE21]
    assign in_acc = '{rs: register_select, data: wr_byte};

    // ==================================================================
    // Write queue
    cdh_fifo #(
        .WIDTH($bits(cdh_acc_s)),
        .DEPTH(CDH_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .in_valid(byte_done),
        .in_ready(fifo_ready),
        .in_data(in_acc),
        .out_valid(q_valid),
        .out_ready(q_pop),
        .out_data(q_acc)
    );
    assign host_ready = fifo_ready;
    assign q_pop = q_valid & (state_r == CDH_IDLE);

    // ==================================================================
    // Pointer stepping and shift wrap
    assign step_ptr = inc_r ? ptr_r + 7'h01 : ptr_r - 7'h01;    // [RULE11]

    always_comb begin
        sh_nxt = shift_r;
        if (!q_acc.data[2]) begin
            if (lines2_r) begin
                sh_nxt = (shift_r == CDH_LINE1_END) ? 7'h00
                                                    : shift_r + 7'h01;
            end else begin
                sh_nxt = (shift_r == CDH_ONE_END) ? 7'h00
                                                  : shift_r + 7'h01;
            end
        end else begin
            if (shift_r == 7'h00) begin
                sh_nxt = lines2_r ? CDH_LINE1_END : CDH_ONE_END; // [RULE17]
            end else begin
                sh_nxt = shift_r - 7'h01;
            end
        end
    end

    // Two-line mode folds 00..27 and 40..67 onto the 80 entries
    always_comb begin
        if (lines2_r) begin
            dd_idx = ptr_r[6] ? 7'(ptr_r[5:0]) + 7'h28 : 7'(ptr_r[5:0]);
            dd_ok = (7'(ptr_r[5:0]) <= CDH_LINE1_END);      // [RULE16]
        end else begin
            dd_idx = ptr_r;
            dd_ok = (ptr_r <= CDH_ONE_END);                 // [RULE15]
        end
    end

    // ==================================================================
    // Command and transfer execution
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r <= CDH_IDLE;
            cnt_r <= 8'h00;
            ptr_r <= 7'h00;
            cg_sel_r <= 1'b0;
            inc_r <= CDH_RESET_ENTRY[1];
            bus8_r <= CDH_RESET_FUNC[4];
            lines2_r <= 1'b0;
            font10_r <= 1'b0;
            shift_r <= 7'h00;
        end else begin
            case (state_r)
                CDH_IDLE: begin
                    if (q_valid && !q_acc.rs) begin
                        state_r <= CDH_EXEC;                   // [RULE3]
                        cnt_r <= 8'(EXEC_CYC);
                        if (q_acc.data[7]) begin
                            ptr_r <= q_acc.data[6:0];          // [RULE10]
                            cg_sel_r <= 1'b0;
                        end else if (q_acc.data[6]) begin
                            ptr_r <= {1'b0, q_acc.data[5:0]};
                            cg_sel_r <= 1'b1;
                        end else if (q_acc.data[5]) begin
                            bus8_r <= q_acc.data[4];
                            lines2_r <= q_acc.data[3];
                            font10_r <= q_acc.data[2];         // [RULE19]
                        end else if (q_acc.data[4]) begin
                            if (q_acc.data[3]) begin
                                shift_r <= sh_nxt;
                            end else begin
                                ptr_r <= q_acc.data[2] ? ptr_r + 7'h01
                                                       : ptr_r - 7'h01;
                            end
                        end else if (q_acc.data[2]) begin
                            inc_r <= q_acc.data[1];
                        end else if (q_acc.data[1]) begin
                            ptr_r <= 7'h00;
                            shift_r <= 7'h00;
                        end
                    end else if (q_valid && q_acc.rs) begin
                        state_r <= CDH_RAM;                    // [RULE5]
                        cnt_r <= 8'(EXEC_CYC);
                        ptr_r <= step_ptr;
                    end else if (rise && register_select &&
                                 direction_select &&
                                 (bus8_r || nib_hi_r)) begin
                        state_r <= CDH_WAIT;                   // [RULE6]
                        cnt_r <= 8'(EXEC_CYC);
                    end
                end
                CDH_EXEC, CDH_RAM: begin
                    if (cnt_r <= 8'h01) begin
                        state_r <= CDH_IDLE;                   // [RULE9]
                    end else begin
                        cnt_r <= cnt_r - 8'h01;                // [RULE8]
                    end
                end
                CDH_WAIT: begin
                    if (fall) begin
                        state_r <= CDH_EXEC;
                        ptr_r <= step_ptr;                     // [RULE11]
                        cnt_r <= 8'(EXEC_CYC);
                    end
                end
                default: state_r <= CDH_IDLE;
            endcase
        end
    end

    // RAM write happens as a queued transfer is taken
    always_ff @(posedge ref_clk) begin
        if (state_r == CDH_IDLE && q_valid && q_acc.rs) begin
            if (cg_sel_r) begin
                glyph_ram_r[ptr_r[5:0]] <= q_acc.data;         // [RULE5]
            end else if (dd_ok) begin
                char_ram_r[dd_idx] <= q_acc.data;              // [RULE13]
            end
        end
    end

    // Transfer register captures the RAM byte on a read strobe
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            xfer_r <= 8'h00;
        end else if (state_r == CDH_IDLE && q_valid && q_acc.rs) begin
            xfer_r <= q_acc.data;
        end else if (rise && register_select && direction_select &&
                     (bus8_r || nib_hi_r)) begin
            if (cg_sel_r) begin
                xfer_r <= glyph_ram_r[ptr_r[5:0]];             // [RULE6]
            end else if (dd_ok) begin
                xfer_r <= char_ram_r[dd_idx];
            end else begin
                xfer_r <= 8'h00;
            end
        end
    end

    // ==================================================================
    // Read path
    assign busy_indication = (state_r != CDH_IDLE) | q_valid;  // [RULE8]
    assign rd_byte = register_select ? xfer_r                  // [RULE1]
                   : {busy_indication, ptr_r};                 // [RULE4] [RULE7]

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rd_hi_r <= 1'b1;
        end else if (rise && direction_select && !bus8_r) begin
            rd_hi_r <= ~rd_hi_r;                               // [RULE22]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            high_nibble_lines_out <= 4'h0;
            low_nibble_lines_out <= 4'h0;
        end else begin
            // After a rise the flag already points to the next nibble
            high_nibble_lines_out <= (bus8_r || !rd_hi_r) ? rd_byte[7:4]
                                                         : rd_byte[3:0];
            low_nibble_lines_out <= rd_byte[3:0];
        end
    end

    // Drive only during a read strobe; low lines idle in 4-bit mode
    assign high_nibble_lines_oe_n = ~(strobe & strobe_d_r &
                                      direction_select);       // [RULE21]
    assign low_nibble_lines_oe_n = ~(strobe & strobe_d_r &
                                     direction_select & bus8_r); // [RULE14]

    // ==================================================================
    // Display mapping, duty and commons
    assign address_pointer = ptr_r;                            // [RULE12]
    assign bus_8bit = bus8_r;
    assign two_line = lines2_r;
    assign tall_font = font10_r & ~lines2_r;
    assign duty = lines2_r ? CDH_DUTY_16
                : (font10_r ? CDH_DUTY_11 : CDH_DUTY_8);       // [RULE19]
    assign window_line1 = shift_r;                             // [RULE15]
    assign window_line2 = CDH_LINE2_BASE + shift_r;            // [RULE16]

    always_comb begin
        expansion_line1 = shift_r + 7'h08;                     // [RULE18]
        expansion_line2 = window_line2 + 7'h08;
        if (!lines2_r && expansion_line1 > CDH_ONE_END) begin
            expansion_line1 = expansion_line1 - 7'(CDH_DD_DEPTH);
        end else if (lines2_r && expansion_line1 > CDH_LINE1_END) begin
            expansion_line1 = expansion_line1 - 7'h28;
            expansion_line2 = expansion_line2 - 7'h28;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_com
            assign common_active[gi] = (5'(gi) < duty);        // [RULE20]
        end
    endgenerate
endmodule

// >>> rtl/cdh_pkg.sv
// Package of constants and types for the character display host port
// =====================================================================
// Overview of operation
// RULE1 - Register select low picks command register, high picks transfer register.
// RULE2 - Direction select low writes, high reads.
// RULE3 - Command write latches bus byte into command register and starts it.
// RULE4 - Command read returns busy on bit 7, pointer on bits 6..0.
// RULE5 - Transfer write stores byte into character or pattern RAM at pointer.
// RULE6 - Transfer read fetches RAM byte at pointer and presents it to host.
// RULE7 - Command register is write only; holds commands and address loads.
// RULE8 - Busy stays 1 during internal work; new commands are ignored then. The code instead queues up to 16 writes in the write FIFO.
// RULE9 - Busy returns to 0 when the internal operation completes.
// RULE10 - Address commands load the pointer and choose character or pattern RAM.
// RULE11 - Pointer steps up or down by one after each RAM access.
// RULE12 - Pointer is seven bits wide and holds a binary address.
// RULE13 - Character RAM holds 80 bytes; unshown entries are general storage.
// RULE14 - In four-bit mode only the upper four data lines are used.
// RULE15 - One-line mode maps positions 1..80 to addresses 00..4F.
// RULE16 - Two-line mode uses 00..27 for line one and 40..67 for two.
// RULE17 - Display shift moves window by one, wrapping at 4F, 27 or 67.
// RULE18 - Sixteen-wide panels send positions 9..16 addresses to expansion driver.
// RULE19 - Duty selectable as 1/8, 1/11 or 1/16 by line and font mode.
// RULE20 - Unused commons carry non-selection: 9..16 at 1/8, 12..16 at 1/11.
// RULE21 - Write data taken on strobe fall; read data driven while strobe high. The code drives read data from the second clock of strobe high.
// RULE22 - Four-bit bytes move as two accesses, upper nibble first.
// =====================================================================
package cdh_pkg;
    localparam int CDH_DD_DEPTH = 80;
    localparam int CDH_CG_DEPTH = 64;
    localparam logic [6:0] CDH_LINE1_END = 7'h27;
    localparam logic [6:0] CDH_LINE2_BASE = 7'h40;
    localparam logic [6:0] CDH_LINE2_END = 7'h67;
    localparam logic [6:0] CDH_ONE_END = 7'h4F;
    localparam logic [4:0] CDH_DUTY_8 = 5'h08;
    localparam logic [4:0] CDH_DUTY_11 = 5'h0B;
    localparam logic [4:0] CDH_DUTY_16 = 5'h10;
    localparam int CDH_EXEC_NS = 40;
    localparam int CDH_CLK_NS = 10;
    localparam int CDH_EXEC_CYC = (CDH_EXEC_NS + CDH_CLK_NS - 1) / CDH_CLK_NS;
    localparam int CDH_FIFO_DEPTH = 16;
    localparam logic [7:0] CDH_RESET_ENTRY = 8'h06;
    localparam logic [7:0] CDH_RESET_FUNC = 8'h30;

    typedef struct packed {
        logic rs;
        logic [7:0] data;
    } cdh_acc_s;

    typedef enum logic [3:0] {
        CDH_IDLE = 4'h1,
        CDH_EXEC = 4'h2,
        CDH_RAM = 4'h4,
        CDH_WAIT = 4'h8
    } cdh_state_e;
endpackage
